//--- src/imupd_top.sv
// apb register bank: upper interrupt mask, pre-divider factor, event status
//
// Functional notes
// - mask bit 6 gates second path state change
// - mask bit 4 gates all second-path inputs lost
// - mask bit 3 gates line two code violation
// - mask bit 2 gates line two signal loss
// - mask bit 1 gates line one code violation
// - mask bit 0 gates line one signal loss
// - low divider byte read/write, resets to FF
// - high divider six bits read/write, resets 3F
// - reference divided by factor plus one
//
// register map, byte address is four times the index:
//   0x45 upper interrupt mask, 0x46 factor low byte,
//   0x47 factor high six bits, 0x48 sticky event status (write one to clear)
// every transfer completes with zero wait states; unmapped places answer
// with pslverr and read as zero, so software can probe the map safely
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "imupd_map.svh"
module imupd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire imupd_pkg::imupd_events_t events,
  input wire logic divn_ref_in,
  output logic divn_pulse,
  output logic [13:0] divn_factor,
  output logic irq
);
  // bus request gathered into one carrier
  imupd_pkg::imupd_apb_req_t req;
  assign req = {paddr, pwrite, pwdata, psel, penable};

  // software-visible state
  logic [7:0] mask, next_mask; // upper interrupt mask
  logic [7:0] div_low, next_div_low; // factor bits 7..0
  logic [7:0] div_high, next_div_high; // factor bits 13..8 in low six
  logic [7:0] status; // sticky events, from the irq module
  logic [7:0] clear_bits; // write-one-to-clear pattern this cycle

  // bus answer state
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // decode results
  logic hit_mask, hit_low, hit_high, hit_status, hit_any;
  logic [7:0] rd_byte; // read value of the addressed register

  // phases of a transfer
  logic setup_phase; // first cycle: psel high, penable low
  logic access_done; // access cycle that completes with pready
  logic wr_ok; // write that takes effect at this edge
  assign setup_phase = req.sel & ~req.enable;
  assign access_done = req.sel & req.enable & pready;
  // a lane-0 strobe is needed since every register lives in byte 0;
  // a refused write keeps the old value rather than corrupting it
  assign wr_ok = access_done & req.write & ~pslverr & pstrb[0];

  // address decode and read mux; unmapped reads give zero
  always_comb begin
    hit_mask = 1'b0;
    hit_low = 1'b0;
    hit_high = 1'b0;
    hit_status = 1'b0;
    rd_byte = 8'h00;
    if (req.addr == imupd_pkg::imupd_byte_addr(`IMUPD_IDX_MASK_UPPER)) begin
      hit_mask = 1'b1;
      rd_byte = mask;
    end else if (req.addr == imupd_pkg::imupd_byte_addr(`IMUPD_IDX_DIV_LOW)) begin
      hit_low = 1'b1;
      rd_byte = div_low;
    end else if (req.addr == imupd_pkg::imupd_byte_addr(`IMUPD_IDX_DIV_HIGH)) begin
      hit_high = 1'b1;
      rd_byte = div_high;
    end else if (req.addr == imupd_pkg::imupd_byte_addr(`IMUPD_IDX_IRQ_STATUS)) begin
      hit_status = 1'b1;
      rd_byte = status;
    end
    hit_any = hit_mask | hit_low | hit_high | hit_status;
  end

  // bus answer: prepared in setup; ready and error shown for exactly the access cycle, read data held until the next setup
  always_comb begin
    next_pready = setup_phase;
    next_pslverr = setup_phase & ~hit_any;
    next_prdata = prdata;
    if (setup_phase) begin
      // writes read back zero so the bus does not carry stale data
      next_prdata = req.write ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
  end

  // register updates from software writes
  always_comb begin
    next_mask = mask;
    next_div_low = div_low;
    next_div_high = div_high;
    clear_bits = 8'h00;
    if (wr_ok && hit_mask) begin
      // unused bits 7 and 5 are not stored and read as zero
      next_mask = req.wdata[7:0] & `IMUPD_EVENT_USED;
    end
    if (wr_ok && hit_low) begin
      next_div_low = req.wdata[7:0];
    end
    if (wr_ok && hit_high) begin
      // top two bits unused; no clamp on the factor, software keeps it legal
      next_div_high = req.wdata[7:0] & `IMUPD_DIV_HIGH_USED;
    end
    if (wr_ok && hit_status) begin
      clear_bits = req.wdata[7:0];
    end
  end

  // registers of the bank and the bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= `IMUPD_RST_MASK_UPPER;
      div_low <= `IMUPD_RST_DIV_LOW;
      div_high <= `IMUPD_RST_DIV_HIGH;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      mask <= next_mask;
      div_low <= next_div_low;
      div_high <= next_div_high;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // factor straight from the two divider registers
  assign divn_factor = {div_high[5:0], div_low};

  // sticky status and masked interrupt; next mask keeps irq in step
  imupd_irq i_imupd_irq (
    .pclk(pclk),
    .presetn(presetn),
    .events(events),
    .clear_bits(clear_bits),
    .next_mask(next_mask),
    .status(status),
    .irq(irq)
  );

  // pre-divider for the divide-by-n reference input
  imupd_divn i_imupd_divn (
    .pclk(pclk),
    .presetn(presetn),
    .ref_in(divn_ref_in),
    .factor(divn_factor),
    .div_pulse(divn_pulse)
  );

  // checks on the bank
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // one masked event alone drives irq exactly as its mask bit says
  property p_gate(int b);
    (status == (8'h01 << b)) |-> (irq == mask[b]);
  endproperty

  a_gate_state_change: assert property (p_gate(`IMUPD_BIT_STATE_CHANGE))
    else $error("state change interrupt not gated by mask bit 6");
  a_gate_all_lost: assert property (p_gate(`IMUPD_BIT_ALL_LOST))
    else $error("all inputs lost interrupt not gated by mask bit 4");
  a_gate_l2_viol: assert property (p_gate(`IMUPD_BIT_L2_VIOL))
    else $error("line two violation interrupt not gated by mask bit 3");
  a_gate_l2_loss: assert property (p_gate(`IMUPD_BIT_L2_LOSS))
    else $error("line two loss interrupt not gated by mask bit 2");
  a_gate_l1_viol: assert property (p_gate(`IMUPD_BIT_L1_VIOL))
    else $error("line one violation interrupt not gated by mask bit 1");
  a_gate_l1_loss: assert property (p_gate(`IMUPD_BIT_L1_LOSS))
    else $error("line one loss interrupt not gated by mask bit 0");

  // a written low byte is held unchanged in the register one cycle later
  sequence s_write_low;
    wr_ok && hit_low;
  endsequence
  a_low_byte_write: assert property (s_write_low |=> div_low == $past(pwdata[7:0]))
    else $error("low divider byte not stored");

  // high byte keeps only six bits
  sequence s_write_high;
    wr_ok && hit_high;
  endsequence
  a_high_byte_write: assert property (s_write_high |=>
    (div_high == {2'h0, $past(pwdata[5:0])}))
    else $error("high divider byte not stored as six bits");

  // an event reaches status whatever the mask holds
  a_event_recorded: assert property (((events & `IMUPD_EVENT_USED) != 8'h00) |=>
    ((status & $past(events & `IMUPD_EVENT_USED)) == $past(events & `IMUPD_EVENT_USED)))
    else $error("event lost from status");

  // interrupt level follows unmasked status in the same cycle
  a_irq_level_match: assert property (irq == |(status & mask))
    else $error("interrupt level disagrees with status and mask");

  // zero-wait answer: ready for one cycle after each setup
  a_ready_one_cycle: assert property (setup_phase |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");

  // unmapped addresses answer with an error in the access cycle
  a_unmapped_error: assert property ((setup_phase && !hit_any) |=> (pready && pslverr))
    else $error("unmapped address did not report an error");

  // mapped addresses never raise an error
  a_mapped_no_error: assert property ((setup_phase && hit_any) |=> (pready && !pslverr))
    else $error("mapped address reported an error");

  // an error is only ever shown together with ready
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr shown without pready");

  // bits that carry no function never hold a one, whatever software writes
  a_mask_unused_zero: assert property ((mask & ~`IMUPD_EVENT_USED) == 8'h00)
    else $error("unused mask bit holds a one");
  a_high_unused_zero: assert property (div_high[7:6] == 2'h0)
    else $error("unused divider bits hold a one");
  a_status_unused_zero: assert property ((status & ~`IMUPD_EVENT_USED) == 8'h00)
    else $error("unused status bit holds a one");

  // a clear mask keeps the interrupt low whatever status has recorded
  a_masked_quiet: assert property ((mask == 8'h00) |-> !irq)
    else $error("interrupt raised with every mask bit clear");

  // a mask write keeps only the bits that carry a function
  sequence s_write_mask;
    wr_ok && hit_mask;
  endsequence
  a_mask_write: assert property (s_write_mask |=>
    (mask == ($past(req.wdata[7:0]) & `IMUPD_EVENT_USED)))
    else $error("mask write not stored as its used bits");

  // a read setup of one register, answered in the following access cycle
  sequence s_read_setup(hit);
    setup_phase && !req.write && hit;
  endsequence
  a_read_mask: assert property (s_read_setup(hit_mask) |=>
    (prdata == {24'h00_0000, $past(mask)}))
    else $error("mask read data wrong");
  a_read_low: assert property (s_read_setup(hit_low) |=>
    (prdata == {24'h00_0000, $past(div_low)}))
    else $error("low divider read data wrong");
  a_read_high: assert property (s_read_setup(hit_high) |=>
    (prdata == {24'h00_0000, $past(div_high)}))
    else $error("high divider read data wrong");
  a_read_status: assert property (s_read_setup(hit_status) |=>
    (prdata == {24'h00_0000, $past(status)}))
    else $error("status read data wrong");

  // upper read data lanes are always zero in the access cycle
  a_read_upper_zero: assert property (pready |-> (prdata[31:8] == 24'h00_0000))
    else $error("upper read data lanes not zero");

  // a write answers with zero read data
  a_write_reads_zero: assert property ((setup_phase && req.write) |=>
    (prdata == 32'h0000_0000))
    else $error("write answered with nonzero read data");

  // read data stands until the next setup prepares a new answer
  a_prdata_holds: assert property (!setup_phase |=> $stable(prdata))
    else $error("read data changed outside a setup");

  // refused writes, by error or by a missing lane-0 strobe, change nothing
  sequence s_refused_write;
    access_done && req.write && (pslverr || !pstrb[0]);
  endsequence
  a_refused_write: assert property (s_refused_write |=>
    ($stable(mask) && $stable(div_low) && $stable(div_high)))
    else $error("refused write changed a register");

  // write one to clear removes each written bit unless an event sets it again
  sequence s_status_clear;
    wr_ok && hit_status;
  endsequence
  a_status_clear: assert property (s_status_clear |=>
    ((status & $past(clear_bits & ~(events & `IMUPD_EVENT_USED))) == 8'h00))
    else $error("status bit not cleared by a write of one");
endmodule
`default_nettype wire

//--- inc/imupd_map.svh
// register indices, reset values and field positions of the mask and divider bank
`ifndef IMUPD_MAP_SVH
`define IMUPD_MAP_SVH
// register indices; byte address is four times the index
`define IMUPD_IDX_MASK_UPPER 8'h45
`define IMUPD_IDX_DIV_LOW 8'h46
`define IMUPD_IDX_DIV_HIGH 8'h47
`define IMUPD_IDX_IRQ_STATUS 8'h48
// reset values
`define IMUPD_RST_MASK_UPPER 8'h00
`define IMUPD_RST_DIV_LOW 8'hFF
`define IMUPD_RST_DIV_HIGH 8'h3F
`define IMUPD_RST_STATUS 8'h00
// bits that carry a function; the rest read as zero
`define IMUPD_EVENT_USED 8'h5F
`define IMUPD_DIV_HIGH_USED 8'h3F
// event bit positions
`define IMUPD_BIT_STATE_CHANGE 6
`define IMUPD_BIT_ALL_LOST 4
`define IMUPD_BIT_L2_VIOL 3
`define IMUPD_BIT_L2_LOSS 2
`define IMUPD_BIT_L1_VIOL 1
`define IMUPD_BIT_L1_LOSS 0
`endif

//--- inc/imupd_pkg.sv
// types shared by the mask and divider bank
`include "imupd_map.svh"
package imupd_pkg;
  // apb request as seen by the slave
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
    logic sel;
    logic enable;
  } imupd_apb_req_t;
  // event pulses, laid out like the mask register
  typedef struct packed {
    logic pad7;
    logic second_path_state_change;
    logic pad5;
    logic second_path_all_inputs_lost;
    logic line_two_code_violation;
    logic line_two_signal_loss;
    logic line_one_code_violation;
    logic line_one_signal_loss;
  } imupd_events_t;
  // byte address of a register index
  function automatic logic [11:0] imupd_byte_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
endpackage

//--- src/imupd_divn.sv
// divide-by-n pre-divider: one pulse per factor plus one reference edges
`timescale 1ns/10ps
`default_nettype none
module imupd_divn (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ref_in,
  input wire logic [13:0] factor,
  output logic div_pulse
);
  logic sync1, sync2, sync3; // pin synchroniser plus edge history
  logic [13:0] cnt, next_cnt; // reference edges since last pulse
  logic next_div_pulse;
  logic edge_seen; // rising edge of the synchronised reference
  assign edge_seen = sync2 & ~sync3;
  // count edges; >= keeps a lowered factor from running the counter round
  always_comb begin
    next_cnt = cnt;
    next_div_pulse = 1'b0;
    if (edge_seen) begin
      if (cnt >= factor) begin
        next_cnt = 14'h0000;
        next_div_pulse = 1'b1;
      end else begin
        next_cnt = cnt + 14'h0001;
      end
    end
  end
  // registers; sync1 is read only by sync2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      cnt <= 14'h0000;
      div_pulse <= 1'b0;
    end else begin
      sync1 <= ref_in;
      sync2 <= sync1;
      sync3 <= sync2;
      cnt <= next_cnt;
      div_pulse <= next_div_pulse;
    end
  end
  // the edge that completes a group of factor plus one
  sequence s_wrap;
    edge_seen && (cnt == factor);
  endsequence
  a_div_wrap_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_wrap |=> div_pulse && (cnt == 14'h0000))
    else $error("divider did not pulse at the wrapping edge");
endmodule
`default_nettype wire

//--- src/imupd_irq.sv
// sticky event status and masked interrupt level
`timescale 1ns/10ps
`default_nettype none
`include "imupd_map.svh"
module imupd_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire imupd_pkg::imupd_events_t events,
  input wire logic [7:0] clear_bits,
  input wire logic [7:0] next_mask,
  output logic [7:0] status,
  output logic irq
);
  logic [7:0] next_status;
  logic next_irq;
  // set wins over a same-cycle clear; the mask never blocks recording
  always_comb begin
    next_status = (status & ~clear_bits) | (events & `IMUPD_EVENT_USED);
    next_irq = |(next_status & next_mask);
  end
  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= `IMUPD_RST_STATUS;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= next_irq;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the mask and divider register bank
`timescale 1ns/10ps
`default_nettype none
`include "imupd_map.svh"
module tb;
  // one table row: request and the answer it should give
  typedef struct {
    logic w;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [3:0] st;
    logic [31:0] rd;
    logic err;
  } imupd_row_t;
  logic pclk, presetn, psel, penable, pwrite, divn_ref_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, divn_pulse, irq, er;
  logic [13:0] divn_factor;
  imupd_pkg::imupd_events_t ev; // event pulses driven by the bench
  int mismatches, cmp_count, pulses;
  imupd_row_t rows[12];
  imupd_top i_imupd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(ev), .divn_ref_in(divn_ref_in),
    .divn_pulse(divn_pulse), .divn_factor(divn_factor), .irq(irq));
  // 100 ns clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // count divider pulses; sampled at the edge so a one-cycle pulse is never missed
  always @(posedge pclk) begin
    if (divn_pulse === 1'b1) begin
      pulses++;
    end
  end
  // compare a value; four-state so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [3:0] st);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    chk(n, 1, "wait states");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one-cycle event pulse, then settle past the updating edge
  task automatic pulse_event(input logic [7:0] b);
    @(posedge pclk);
    ev <= b;
    @(posedge pclk);
    ev <= 8'h00;
    @(negedge pclk);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog: the tests need well under 2000 cycles
  initial begin
    #(20000 * 100);
    mismatches++;
    final_report();
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    divn_ref_in = 1'b0;
    ev = 8'h00;
    rows = '{
      '{0, 8'h45, 8'h00, 4'hF, 32'h00, 0}, '{0, 8'h46, 8'h00, 4'hF, 32'hFF, 0},
      '{0, 8'h47, 8'h00, 4'hF, 32'h3F, 0}, '{0, 8'h48, 8'h00, 4'hF, 32'h00, 0},
      '{1, 8'h45, 8'h5F, 4'hF, 32'h00, 0}, '{0, 8'h45, 8'h00, 4'hF, 32'h5F, 0},
      '{1, 8'h46, 8'hA5, 4'hF, 32'h00, 0}, '{0, 8'h46, 8'h00, 4'hF, 32'hA5, 0},
      '{1, 8'h47, 8'h12, 4'h0, 32'h00, 0}, '{0, 8'h47, 8'h00, 4'hF, 32'h3F, 0},
      '{1, 8'h49, 8'h33, 4'hF, 32'h00, 1}, '{0, 8'h49, 8'h00, 4'hF, 32'h00, 1}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // register table: reset values, access kinds, a write without lane-0 strobe, unmapped place
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].idx, rows[i].wd, rows[i].st);
      chk({31'h0, er}, {31'h0, rows[i].err}, "response");
      if (!rows[i].w) begin
        chk(rd, rows[i].rd, "read data");
      end
    end
    chk({18'h0, divn_factor}, 32'h3FA5, "factor");
    $display("test registers done");
    // each used mask bit (not 7 or 5): blocked while clear, passes when set, status always records
    apb(1, 8'h45, 8'h00, 4'hF);
    for (int b = 0; b < 7; b++) begin
      if (b == 5) begin
        continue;
      end
      pulse_event(8'h01 << b);
      chk({31'h0, irq}, 32'h0, "masked irq");
      apb(0, 8'h48, 8'h00, 4'hF);
      chk(rd, 32'h1 << b, "status while masked");
      apb(1, 8'h45, 8'h01 << b, 4'hF);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h1, "pending irq on unmask");
      apb(1, 8'h48, 8'h01 << b, 4'hF);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0, "irq after clear");
      pulse_event(8'h01 << b);
      chk({31'h0, irq}, 32'h1, "unmasked irq");
      apb(1, 8'h45, 8'h00, 4'hF);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0, "irq after mask");
      apb(0, 8'h48, 8'h00, 4'hF);
      chk(rd, 32'h1 << b, "status kept");
      apb(1, 8'h48, 8'h01 << b, 4'hF);
    end
    $display("test masks done");
    // event on the very edge that clears it: the set wins
    pulse_event(8'h01);
    fork
      apb(1, 8'h48, 8'h01, 4'hF);
      begin
        repeat (2) @(posedge pclk);
        ev <= 8'h01;
        @(posedge pclk);
        ev <= 8'h00;
      end
    join
    apb(0, 8'h48, 8'h00, 4'hF);
    chk(rd, 32'h1, "set wins over clear");
    apb(1, 8'h48, 8'h01, 4'hF);
    $display("test set wins done");
    // factor 2 divides by 3: nine reference edges give three pulses
    apb(1, 8'h46, 8'h02, 4'hF);
    apb(1, 8'h47, 8'hC0, 4'hF);
    apb(0, 8'h47, 8'h00, 4'hF);
    chk(rd, 32'h00, "high byte unused bits");
    pulses = 0;
    repeat (9) begin
      repeat (2) @(posedge pclk);
      divn_ref_in <= 1'b1;
      repeat (2) @(posedge pclk);
      divn_ref_in <= 1'b0;
    end
    repeat (6) @(posedge pclk);
    chk(pulses, 3, "divider pulses");
    $display("test divider done");
    // reset in mid-run restores the factor, irq and the mask
    apb(1, 8'h45, 8'h5F, 4'hF);
    @(posedge pclk);
    presetn <= 1'b0;
    #10;
    chk({18'h0, divn_factor}, 32'h3FFF, "factor in reset");
    chk({31'h0, irq}, 32'h0, "irq in reset");
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h45, 8'h00, 4'hF);
    chk(rd, 32'h0, "mask after reset");
    $display("test reset done");
    final_report();
  end
endmodule
`default_nettype wire
